// *** hw/afc_pkg.sv ***
// package: constants and carriers for the external fifo controller
//
// Behaviour
// - controller keeps push, pop high during replay
// - replay block at most 8192, no rewrap
// - cascade chain wired as a ring
// - exactly one cascaded device has lead low
// - composite flags by OR of flags; flags_sync takes the one device's flags with no OR
// - width expansion: standalone, composite flags
package afc_pkg;
   localparam int DEPTH = 8192;
   localparam int WIDTH = 9;
   localparam int HALF = 4096;
   // strobe timings in ns, rounded up to whole cycles
   localparam int CLK_NS = 8;
   localparam int STROBE_NS = 50;
   localparam int RECOV_NS = 15;
   localparam int CLEAR_NS = 100;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECOV_CYC = (RECOV_NS + CLK_NS - 1) / CLK_NS;
   localparam int CLEAR_CYC = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0] MODE_ALONE = 2'h0;
   localparam logic [1:0] MODE_LEAD = 2'h1;
   localparam logic [1:0] MODE_FOLLOW = 2'h2;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_PUSH,
      OP_POP,
      OP_REPLAY,
      OP_CLEAR
   } afc_op_t;

   typedef struct packed {
      logic empty_flag_n;
      logic full_flag_n;
      logic half_full_flag_n;
   } afc_flags_t;
endpackage

// *** hw/afc_ctrl.sv ***
// external controller driving one fifo through its strobe pins
`timescale 1ns/10ps
`default_nettype none
module afc_ctrl #(
   parameter int STROBE_CYC = afc_pkg::STROBE_CYC,
   parameter int RECOV_CYC = afc_pkg::RECOV_CYC,
   parameter int CLEAR_CYC = afc_pkg::CLEAR_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // user orders
   input wire logic cmd_valid,
   input wire afc_pkg::afc_op_t cmd_op,
   input wire logic [afc_pkg::WIDTH-1:0] cmd_wdata,
   input wire logic [1:0] cmd_mode,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [afc_pkg::WIDTH-1:0] rsp_rdata,
   output logic rsp_refused,
   output afc_pkg::afc_flags_t flags_sync,
   // fifo pins
   output logic push_n,
   output logic pop_n,
   output logic clear_n,
   output logic chain_in_n,
   output logic lead_select_or_replay_n,
   output logic [afc_pkg::WIDTH-1:0] write_data_in,
   input wire logic [afc_pkg::WIDTH-1:0] read_data_out,
   input wire logic empty_flag_n,
   input wire logic full_flag_n,
   input wire logic chain_out_or_half_full_n
);
   typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_RECOV} afc_state_t;
   afc_state_t state_r;
   afc_pkg::afc_op_t op_r;
   logic [7:0] cnt_r;
   logic [1:0] mode_r;
   afc_pkg::afc_flags_t meta_r;
   logic [afc_pkg::WIDTH-1:0] dmeta_r;
   logic [afc_pkg::WIDTH-1:0] dsync_r;
   logic cmd_take;
   logic push_go;
   logic [13:0] wr_cnt_r;
   logic block_long;

   assign cmd_take = cmd_valid && cmd_ready;
   assign push_go = cmd_take && cmd_op == afc_pkg::OP_PUSH && flags_sync.full_flag_n;

   // writes since clear; saturates so a long run cannot wrap back to legal
   always_ff @(posedge core_clk) begin
      if (srst || (cmd_take && cmd_op == afc_pkg::OP_CLEAR)) begin
         wr_cnt_r <= 14'h0000;
      end else if (push_go && wr_cnt_r <= 14'(afc_pkg::DEPTH)) begin
         wr_cnt_r <= wr_cnt_r + 14'h0001;
      end
   end

   // a replayed block longer than the array has lost its oldest words
   assign block_long = int'(wr_cnt_r) > afc_pkg::DEPTH;

   // pins pass two flops; flag meanings depend on mode
   always_ff @(posedge core_clk) begin
      meta_r <= '{empty_flag_n, full_flag_n, chain_out_or_half_full_n};
      dmeta_r <= read_data_out;
      // lone device, so its own flags are the composite flags
      flags_sync <= meta_r;
      dsync_r <= dmeta_r;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_r <= ST_IDLE;
         op_r <= afc_pkg::OP_NONE;
         cnt_r <= 8'h00;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_refused <= 1'b0;
         rsp_rdata <= 9'h000;
         push_n <= 1'b1;
         pop_n <= 1'b1;
         clear_n <= 1'b1;
         chain_in_n <= 1'b0;
         lead_select_or_replay_n <= 1'b1;
         write_data_in <= 9'h000;
         mode_r <= afc_pkg::MODE_ALONE;
      end else begin
         rsp_valid <= 1'b0;
         rsp_refused <= 1'b0;
         unique case (state_r)
            ST_IDLE: begin
               cmd_ready <= 1'b1;
               if (cmd_take) begin
                  cmd_ready <= 1'b0;
                  op_r <= cmd_op;
                  cnt_r <= 8'h00;
                  state_r <= ST_ACTIVE;
                  unique case (cmd_op)
                     afc_pkg::OP_PUSH: begin
                        // refuse on full so no write is lost silently
                        if (!flags_sync.full_flag_n) begin
                           rsp_valid <= 1'b1;
                           rsp_refused <= 1'b1;
                           state_r <= ST_IDLE;
                        end else begin
                           write_data_in <= cmd_wdata;
                           push_n <= 1'b0;
                        end
                     end
                     afc_pkg::OP_POP: begin
                        if (!flags_sync.empty_flag_n) begin
                           rsp_valid <= 1'b1;
                           rsp_refused <= 1'b1;
                           state_r <= ST_IDLE;
                        end else begin
                           pop_n <= 1'b0;
                        end
                     end
                     afc_pkg::OP_REPLAY: begin
                        // replay pin is lead select when cascaded
                        if (mode_r != afc_pkg::MODE_ALONE || block_long) begin
                           rsp_valid <= 1'b1;
                           rsp_refused <= 1'b1;
                           state_r <= ST_IDLE;
                        end else begin
                           // strobes already high in idle
                           lead_select_or_replay_n <= 1'b0;
                        end
                     end
                     afc_pkg::OP_CLEAR: begin
                        // straps set in the same cycle clear goes low; sampled by device as clear rises
                        mode_r <= cmd_mode;
                        clear_n <= 1'b0;
                        // lone device: strap stands in for the ring's previous output
                        chain_in_n <= (cmd_mode != afc_pkg::MODE_ALONE);
                        lead_select_or_replay_n <=
                           (cmd_mode != afc_pkg::MODE_LEAD);
                     end
                     default: begin
                        rsp_valid <= 1'b1;
                        state_r <= ST_IDLE;
                     end
                  endcase
               end
            end
            ST_ACTIVE: begin
               cnt_r <= cnt_r + 8'h01;
               if (op_r == afc_pkg::OP_CLEAR ? (int'(cnt_r) >= CLEAR_CYC - 1)
                                             : (int'(cnt_r) >= STROBE_CYC - 1)) begin
                  cnt_r <= 8'h00;
                  state_r <= ST_RECOV;
                  push_n <= 1'b1;
                  pop_n <= 1'b1;
                  clear_n <= 1'b1;
                  if (op_r == afc_pkg::OP_REPLAY) begin
                     lead_select_or_replay_n <= 1'b1;
                  end
                  // data sampled while pop still low
                  if (op_r == afc_pkg::OP_POP) begin
                     rsp_rdata <= dsync_r;
                  end
               end
            end
            ST_RECOV: begin
               cnt_r <= cnt_r + 8'h01;
               // recovery also lets flags settle through synchroniser
               if (int'(cnt_r) >= RECOV_CYC + 2) begin
                  rsp_valid <= 1'b1;
                  state_r <= ST_IDLE;
                  cmd_ready <= 1'b1;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// *** sim/afc_ctrl_asserts.sv ***
// checker: strobe and strap timing of the fifo controller
`timescale 1ns/10ps
`default_nettype none
module afc_ctrl_asserts #(
   parameter int STROBE_CYC = afc_pkg::STROBE_CYC,
   parameter int CLEAR_CYC = afc_pkg::CLEAR_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // user orders
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire afc_pkg::afc_op_t cmd_op,
   input wire logic [1:0] cmd_mode,
   input wire logic [8:0] cmd_wdata,
   input wire afc_pkg::afc_flags_t flags_sync,
   // fifo pins
   input wire logic push_n,
   input wire logic pop_n,
   input wire logic clear_n,
   input wire logic chain_in_n,
   input wire logic lead_select_or_replay_n,
   input wire logic [8:0] write_data_in
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   chk_replay_quiet: assert property (!chain_in_n && !lead_select_or_replay_n |-> push_n && pop_n)
      else $error("replay overlaps a strobe");
   chk_push_full: assert property ($fell(push_n) |-> $past(flags_sync.full_flag_n))
      else $error("push while full");
   chk_pop_empty: assert property ($fell(pop_n) |-> $past(flags_sync.empty_flag_n))
      else $error("pop while empty");
   chk_push_width: assert property ($fell(push_n) |-> ##STROBE_CYC $rose(push_n))
      else $error("push strobe width");
   chk_pop_width: assert property ($fell(pop_n) |-> ##STROBE_CYC $rose(pop_n))
      else $error("pop strobe width");
   chk_clear_width: assert property ($fell(clear_n) |-> ##CLEAR_CYC $rose(clear_n))
      else $error("clear strobe width");
   chk_strap_hold: assert property (!clear_n && !$past(clear_n)
      |-> $stable(chain_in_n) && $stable(lead_select_or_replay_n))
      else $error("strap moved in clear");
   chk_lead_strap: assert property (cmd_valid && cmd_ready && cmd_op == afc_pkg::OP_CLEAR
      && cmd_mode == afc_pkg::MODE_LEAD |=> !clear_n && chain_in_n && !lead_select_or_replay_n)
      else $error("lead straps wrong");
   chk_push_data: assert property ($fell(push_n) |-> write_data_in == $past(cmd_wdata))
      else $error("push data wrong");
endmodule
bind afc_ctrl afc_ctrl_asserts #(.STROBE_CYC(STROBE_CYC), .CLEAR_CYC(CLEAR_CYC)) afc_ctrl_asserts_i (.*);
`default_nettype wire

// *** sim/afc_fifo_model.sv ***
// behavioural fifo device answering the controller's strobes
`timescale 1ns/10ps
`default_nettype none
module afc_fifo_model (
   // strobes, straps and data from the controller
   input wire logic push_n,
   input wire logic pop_n,
   input wire logic clear_n,
   input wire logic chain_in_n,
   input wire logic lead_select_or_replay_n,
   input wire logic [8:0] write_data_in,
   // data and flags back
   output logic [8:0] read_data_out,
   output logic empty_flag_n,
   output logic full_flag_n,
   output logic chain_out_or_half_full_n
);
   logic [8:0] mem [8192];
   int wp = 0, rp = 0, n = 0;
   logic cas = 0;
   logic flow = 0;
   initial read_data_out = 9'h000;
   assign empty_flag_n = n != 0;
   assign full_flag_n = n != 8192;
   // cascaded: chain out parked high, half full withheld
   assign chain_out_or_half_full_n = cas | (n <= 4096);
   always @(negedge clear_n) begin
      wp = 0;
      rp = 0;
      n = 0;
   end
   always @(posedge clear_n) cas = chain_in_n;
   // lone device: it alone takes each write and each read
   always @(posedge push_n) if (clear_n === 1 && n < 8192) begin
      mem[wp % 8192] = write_data_in;
      wp++;
      n++;
      // pop held on empty: only the first word flows out
      if (flow && pop_n === 0) begin
         read_data_out = mem[rp % 8192];
         rp++;
         n--;
         flow = 0;
      end
   end
   always @(negedge pop_n) if (n > 0) begin
      read_data_out = mem[rp % 8192];
      rp++;
      n--;
   end else begin
      flow = 1;
   end
   // released bus: no pull, so show the inverse rather than stale data
   always @(posedge pop_n) begin
      read_data_out = ~read_data_out;
      flow = 0;
   end
   // int pointers: no wrap inside a replayed block, so count is write pointer
   always @(negedge lead_select_or_replay_n) if (clear_n === 1 && !cas) begin
      rp = 0;
      n = wp;
   end
endmodule
`default_nettype wire

// *** sim/afc_ctrl_tb.sv ***
// testbench: controller driving the behavioural fifo
`timescale 1ns/10ps
`default_nettype none
module afc_ctrl_tb;
   logic core_clk = 0, srst = 1, cmd_valid = 0;
   afc_pkg::afc_op_t cmd_op = afc_pkg::OP_NONE;
   logic [8:0] cmd_wdata = 9'h000, rsp_rdata, write_data_in, read_data_out;
   logic [1:0] cmd_mode = 2'h0;
   logic cmd_ready, rsp_valid, rsp_refused, push_n, pop_n, clear_n, chain_in_n;
   logic lead_select_or_replay_n, empty_flag_n, full_flag_n, chain_out_or_half_full_n;
   afc_pkg::afc_flags_t flags_sync;
   logic [8:0] pat [3] = '{9'h1a5, 9'h05a, 9'h100};
   int err_total = 0, total_checks = 0, k, j;
   afc_ctrl #(.STROBE_CYC(3), .RECOV_CYC(1), .CLEAR_CYC(2)) afc_ctrl_i (.*);
   afc_fifo_model afc_fifo_model_i (.*);
   task automatic results();
      if (err_total == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [8:0] g, input logic [8:0] e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic op(input afc_pkg::afc_op_t o, input logic [8:0] d, input logic [1:0] m,
         input logic r);
      int i;
      for (i = 0; i < 99 && cmd_ready !== 1; i++) @(posedge core_clk);
      if (i > 98) begin
         err_total++;
         results();
      end
      cmd_valid <= 1;
      cmd_op <= o;
      cmd_wdata <= d;
      cmd_mode <= m;
      @(posedge core_clk);
      cmd_valid <= 0;
      for (i = 0; i < 99 && rsp_valid !== 1; i++) @(posedge core_clk);
      if (i > 98) begin
         err_total++;
         results();
      end
      chk(9'(rsp_refused), 9'(r));
      if (o == afc_pkg::OP_POP && !r) chk(rsp_rdata, d);
   endtask
   // flags pass two sync flops, so let them settle
   task automatic fl(input logic [2:0] e);
      repeat (2) @(posedge core_clk);
      chk(9'(flags_sync), 9'(e));
   endtask
   initial forever #4 core_clk = ~core_clk;
   initial begin
      repeat (3) @(posedge core_clk);
      srst <= 0;
      op(afc_pkg::OP_CLEAR, 9'h000, afc_pkg::MODE_ALONE, 0);
      fl(3'h3);
      op(afc_pkg::OP_POP, 9'h000, 2'h0, 1);
      for (k = 0; k < 3; k++) op(afc_pkg::OP_PUSH, pat[k], 2'h0, 0);
      op(afc_pkg::OP_POP, pat[0], 2'h0, 0);
      for (j = 0; j < 2; j++) begin
         op(afc_pkg::OP_REPLAY, 9'h000, 2'h0, 0);
         for (k = 0; k < 3; k++) op(afc_pkg::OP_POP, pat[k], 2'h0, 0);
         op(afc_pkg::OP_POP, 9'h000, 2'h0, 1);
      end
      op(afc_pkg::OP_CLEAR, 9'h000, afc_pkg::MODE_ALONE, 0);
      for (k = 1; k <= 8192; k++) begin
         op(afc_pkg::OP_PUSH, 9'(k), 2'h0, 0);
         if (k inside {4096, 4097, 8192}) fl(k == 4096 ? 3'h7 : k == 4097 ? 3'h6 : 3'h4);
      end
      op(afc_pkg::OP_PUSH, 9'h000, 2'h0, 1);
      op(afc_pkg::OP_POP, 9'h001, 2'h0, 0);
      fl(3'h6);
      op(afc_pkg::OP_PUSH, 9'h002, 2'h0, 0);
      op(afc_pkg::OP_REPLAY, 9'h000, 2'h0, 1);
      op(afc_pkg::OP_CLEAR, 9'h000, afc_pkg::MODE_LEAD, 0);
      op(afc_pkg::OP_REPLAY, 9'h000, 2'h0, 1);
      fl(3'h3);
      op(afc_pkg::OP_CLEAR, 9'h000, afc_pkg::MODE_FOLLOW, 0);
      fl(3'h3);
      results();
   end
endmodule
`default_nettype wire
